// ### rtl/cid_alu.sv
module cid_alu (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic addMode,
  // Result and flags
  output logic [7:0] result,
  output logic carry,
  output logic digitCarry,
  output logic zero
);
  logic [8:0] sum;
  logic [4:0] lowSum;

  // Carry taps come from the add path even in AND mode; caller ignores them
  assign sum = {1'b0, a} + {1'b0, b};
  assign lowSum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
  assign result = addMode ? sum[7:0] : (a & b);
  assign carry = sum[8];
  assign digitCarry = lowSum[4];
  assign zero = (result == 8'h00);
endmodule : cid_alu

// ### rtl/cid_core.sv
module cid_core
  import cid_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Execution status
  output logic busy,
  output logic nopSlot,
  output logic instrDone,
  // Device side effects
  output logic standby,
  output logic swResetPulse,
  output logic watchdogKickPulse,
  output logic [7:0] optionValue,
  output logic [63:0] pinDirection
);
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EXEC = 1'b1} cid_state_t;

  typedef struct packed {
    cid_state_t state;
    logic [1:0] remain;
    logic [13:0] opcode;
    logic [7:0] acc;
    logic [PC_W-1:0] pc;
    logic [15:0] pointerPair0;
    logic [15:0] pointerPair1;
    logic [7:0] option;
    logic [63:0] pinDir;
    logic [6:0] memIdx;
    logic [MEM_BYTES*8-1:0] mem;
    logic [STACK_DEPTH*PC_W-1:0] stack;
    logic [3:0] sp;
    logic c;
    logic dc;
    logic z;
    logic sleepEnteredFlag;
    logic watchdogExpiryFlag;
    logic gie;
    logic inStandby;
    logic illegal;
    logic swReset;
    logic wdKick;
    logic done;
    logic [31:0] rdata;
  } cid_core_t;

  cid_core_t q;
  cid_core_t n;

  logic accessPh;
  logic setupPh;
  logic known;
  logic wrEn;
  logic startReq;
  cid_op_t opKind;
  logic [1:0] opCycles;
  logic opPtrSel;
  logic windowHit;
  logic [15:0] ptrCur;
  logic [6:0] fileIdx;
  logic [7:0] aluB;
  logic [7:0] aluRes;
  logic aluC;
  logic aluDc;
  logic aluZ;

  // APB phases; zero wait states so access always completes
  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable;
  assign known = (paddr[1:0] == 2'b00) && (paddr <= OFS_MEMDATA);
  assign wrEn = accessPh & pwrite & known;
  assign startReq = wrEn && (paddr == OFS_INSTR) && (q.state == ST_IDLE);
  assign pready = 1'b1;
  // A new instruction while one is running is refused, not queued
  assign pslverr = accessPh & (~known | (pwrite & (paddr == OFS_INSTR) & (q.state != ST_IDLE)));

  // Decoder looks at the incoming word so effects land at the accepting edge
  cid_decode u_decode (
    .opcode(pwdata[13:0]),
    .ptr0Msb(q.pointerPair0[15]),
    .ptr1Msb(q.pointerPair1[15]),
    .opKind(opKind),
    .cycles(opCycles),
    .ptrSel(opPtrSel),
    .windowHit(windowHit)
  );

  // Operand fetch for the file AND; window addresses read through a pointer
  assign ptrCur = opPtrSel ? q.pointerPair1 : q.pointerPair0;
  assign fileIdx = windowHit ? ptrCur[6:0] : pwdata[6:0];
  assign aluB = (opKind == OPK_FILE_AND) ? q.mem[int'(fileIdx)*8 +: 8] : pwdata[7:0];

  cid_alu u_alu (
    .a(q.acc),
    .b(aluB),
    .addMode(opKind == OPK_CONST_ADD),
    .result(aluRes),
    .carry(aluC),
    .digitCarry(aluDc),
    .zero(aluZ)
  );

  // Next-state logic: bus reads, writes, then instruction execution
  always_comb begin
    logic [PC_W-1:0] pcInc;
    logic [3:0] spDec;
    logic [15:0] ptrNew;
    logic [15:0] eff;
    logic [7:0] rdByte;
    logic [31:0] stat;
    logic [13:0] op;
    pcInc = q.pc + 15'h0001;
    spDec = q.sp - 4'h1;
    ptrNew = 16'h0000;
    eff = 16'h0000;
    rdByte = 8'h00;
    stat = 32'h0000_0000;
    op = pwdata[13:0];
    n = q;
    n.swReset = 1'b0;
    n.wdKick = 1'b0;
    n.done = 1'b0;

    // Read data is captured in setup so it leaves a flop during access
    stat[SB_C] = q.c;
    stat[SB_DC] = q.dc;
    stat[SB_Z] = q.z;
    stat[SB_SLEEP_ENTERED] = q.sleepEnteredFlag;
    stat[SB_WATCHDOG_EXPIRY] = q.watchdogExpiryFlag;
    stat[SB_BUSY] = (q.state == ST_EXEC);
    stat[SB_STANDBY] = q.inStandby;
    stat[SB_GIE] = q.gie;
    stat[SB_ILLEGAL] = q.illegal;
    if (setupPh && !pwrite) begin
      case (paddr)
        OFS_INSTR: n.rdata = {18'h00000, q.opcode};
        OFS_STATUS: n.rdata = stat;
        OFS_ACC: n.rdata = {24'h000000, q.acc};
        OFS_PC: n.rdata = {17'h00000, q.pc};
        OFS_PTR0: n.rdata = {16'h0000, q.pointerPair0};
        OFS_PTR1: n.rdata = {16'h0000, q.pointerPair1};
        OFS_OPTION: n.rdata = {24'h000000, q.option};
        OFS_PINDIR_LO: n.rdata = q.pinDir[31:0];
        OFS_PINDIR_HI: n.rdata = q.pinDir[63:32];
        OFS_MEMIDX: n.rdata = {25'h0000000, q.memIdx};
        OFS_MEMDATA: n.rdata = {24'h000000, q.mem[int'(q.memIdx)*8 +: 8]};
        default: n.rdata = 32'h0000_0000;
      endcase
    end

    // Software side writes; status keeps busy and standby read-only
    if (wrEn) begin
      case (paddr)
        OFS_STATUS: begin
          n.c = pwdata[SB_C];
          n.dc = pwdata[SB_DC];
          n.z = pwdata[SB_Z];
          n.sleepEnteredFlag = pwdata[SB_SLEEP_ENTERED];
          n.watchdogExpiryFlag = pwdata[SB_WATCHDOG_EXPIRY];
          n.gie = pwdata[SB_GIE];
          n.illegal = pwdata[SB_ILLEGAL];
        end
        OFS_ACC: n.acc = pwdata[7:0];
        OFS_PC: n.pc = pwdata[PC_W-1:0];
        OFS_PTR0: n.pointerPair0 = pwdata[15:0];
        OFS_PTR1: n.pointerPair1 = pwdata[15:0];
        OFS_MEMIDX: n.memIdx = pwdata[6:0];
        OFS_MEMDATA: n.mem[int'(q.memIdx)*8 +: 8] = pwdata[7:0];
        default: n.memIdx = q.memIdx;
      endcase
    end

    case (q.state)
      ST_IDLE: begin
        if (startReq) begin
          n.opcode = op;
          n.inStandby = 1'b0;
          n.pc = pcInc;
          n.remain = opCycles - 2'h1;
          n.state = (opCycles == CYC_SINGLE) ? ST_IDLE : ST_EXEC;
          n.done = (opCycles == CYC_SINGLE);
          // Pointer modifier: bit 1 picks post, bit 0 picks decrement
          ptrNew = ptrCur + (op[0] ? 16'hffff : 16'h0001);
          eff = op[1] ? ptrCur : ptrNew;
          if (opKind == OPK_POINTER_LOAD_IDX || opKind == OPK_POINTER_STORE_IDX) begin
            eff = ptrCur + sext6(op[5:0]);
          end
          // Data memory is decoded on the low address bits only
          rdByte = q.mem[int'(eff[6:0])*8 +: 8];
          case (opKind)
            OPK_RELATIVE_JUMP: n.pc = pcInc + {{6{op[8]}}, op[8:0]};
            OPK_JUMP_BY_ACCUMULATOR: n.pc = pcInc + {7'h00, q.acc};
            OPK_CALL_SUB, OPK_SUBROUTINE_JUMP_BY_ACC: begin
              // Stack wraps when overfilled, oldest entry is lost
              n.stack[int'(q.sp)*PC_W +: PC_W] = pcInc;
              n.sp = q.sp + 4'h1;
              n.pc = (opKind == OPK_CALL_SUB) ? {q.pc[14:11], op[10:0]}
                : {q.pc[14:8], q.acc};
            end
            OPK_ABSOLUTE_JUMP: n.pc = {q.pc[14:11], op[10:0]};
            OPK_INTERRUPT_EXIT, OPK_RETURN_WITH_CONSTANT, OPK_SUB_RETURN: begin
              n.sp = spDec;
              n.pc = q.stack[int'(spDec)*PC_W +: PC_W];
              if (opKind == OPK_INTERRUPT_EXIT) n.gie = 1'b1;
              if (opKind == OPK_RETURN_WITH_CONSTANT) n.acc = op[7:0];
            end
            OPK_WATCHDOG_KICK: begin
              n.watchdogExpiryFlag = 1'b1;
              n.sleepEnteredFlag = 1'b1;
              n.wdKick = 1'b1;
            end
            OPK_OPTION_LOAD: n.option = q.acc;
            OPK_PIN_DIRECTION_LOAD: n.pinDir[int'(op[2:0])*8 +: 8] = q.acc;
            OPK_SOFT_RESET: begin
              // Core state returns to reset values and gie clears; other status flags survive
              n.swReset = 1'b1;
              n.pc = PC_RESET;
              n.sp = 4'h0;
              n.acc = ACC_RESET;
              n.pointerPair0 = PTR_RESET;
              n.pointerPair1 = PTR_RESET;
              n.option = OPTION_RESET;
              n.pinDir = PINDIR_RESET;
              n.gie = 1'b0;
            end
            OPK_STANDBY: begin
              n.watchdogExpiryFlag = 1'b1;
              n.sleepEnteredFlag = 1'b0;
              n.inStandby = 1'b1;
            end
            OPK_POINTER_ADD_CONST: begin
              // Natural 16-bit overflow gives the wrap
              if (opPtrSel) n.pointerPair1 = ptrCur + sext6(op[5:0]);
              else n.pointerPair0 = ptrCur + sext6(op[5:0]);
            end
            OPK_POINTER_LOAD_ACC, OPK_POINTER_STORE_ACC: begin
              if (opPtrSel) n.pointerPair1 = ptrNew;
              else n.pointerPair0 = ptrNew;
              if (opKind == OPK_POINTER_LOAD_ACC) begin
                n.acc = rdByte;
                n.z = (rdByte == 8'h00);
              end else begin
                n.mem[int'(eff[6:0])*8 +: 8] = q.acc;
              end
            end
            OPK_POINTER_LOAD_IDX: begin
              n.acc = rdByte;
              n.z = (rdByte == 8'h00);
            end
            OPK_POINTER_STORE_IDX: n.mem[int'(eff[6:0])*8 +: 8] = q.acc;
            OPK_CONST_AND: begin
              n.acc = aluRes;
              n.z = aluZ;
            end
            OPK_CONST_ADD: begin
              n.acc = aluRes;
              n.c = aluC;
              n.dc = aluDc;
              n.z = aluZ;
            end
            OPK_FILE_AND: begin
              n.z = aluZ;
              if (op[7]) n.mem[int'(fileIdx)*8 +: 8] = aluRes;
              else n.acc = aluRes;
            end
            OPK_NOP: n.opcode = op;
            default: n.illegal = 1'b1;
          endcase
        end
      end
      ST_EXEC: begin
        // Extra cycles run as no-ops
        n.remain = q.remain - 2'h1;
        if (q.remain == 2'h1) begin
          n.state = ST_IDLE;
          n.done = 1'b1;
        end
      end
      default: n.state = ST_IDLE;
    endcase
  end

  // Single state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.pc <= PC_RESET;
      q.acc <= ACC_RESET;
      q.pointerPair0 <= PTR_RESET;
      q.pointerPair1 <= PTR_RESET;
      q.option <= OPTION_RESET;
      q.pinDir <= PINDIR_RESET;
      q.sleepEnteredFlag <= FLAG_SET_RESET;
      q.watchdogExpiryFlag <= FLAG_SET_RESET;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign prdata = q.rdata;
  assign busy = (q.state == ST_EXEC);
  assign nopSlot = (q.state == ST_EXEC);
  assign instrDone = q.done;
  assign standby = q.inStandby;
  assign swResetPulse = q.swReset;
  assign watchdogKickPulse = q.wdKick;
  assign optionValue = q.option;
  assign pinDirection = q.pinDir;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_REL_JUMP_TWO_CYCLES: assert property (
    startReq && opKind == OPK_RELATIVE_JUMP && !windowHit |=> busy ##1 (!busy && instrDone))
    else $error("relative jump did not take two cycles");
  AST_CALL_PUSHES: assert property (
    startReq && opKind == OPK_CALL_SUB |=> q.sp == $past(q.sp) + 4'h1
      && q.pc[10:0] == $past(pwdata[10:0]))
    else $error("call did not push or jump");
  AST_INT_EXIT_GIE: assert property (
    startReq && opKind == OPK_INTERRUPT_EXIT |=> q.gie && q.sp == $past(q.sp) - 4'h1)
    else $error("interrupt exit did not restore");
  AST_RET_CONST_ACC: assert property (
    startReq && opKind == OPK_RETURN_WITH_CONSTANT |=> q.acc == $past(pwdata[7:0]))
    else $error("constant not loaded on return");
  AST_KICK_FLAGS: assert property (
    startReq && opKind == OPK_WATCHDOG_KICK
      |=> watchdogKickPulse && q.watchdogExpiryFlag && q.sleepEnteredFlag ##1 !watchdogKickPulse)
    else $error("watchdog kick flags wrong");
  AST_SOFT_RESET: assert property (
    startReq && opKind == OPK_SOFT_RESET |=> swResetPulse && q.pc == PC_RESET && !busy)
    else $error("software reset not performed");
  AST_STANDBY_FLAGS: assert property (
    startReq && opKind == OPK_STANDBY |=> standby && !q.sleepEnteredFlag)
    else $error("standby entry flags wrong");
  AST_NOP_SLOT: assert property (
    startReq && opCycles == CYC_PC_CHANGE |=> nopSlot ##1 !nopSlot)
    else $error("no-op slot length wrong");
  AST_WINDOW_EXTRA: assert property (
    startReq && opKind == OPK_POINTER_LOAD_IDX && ptrCur[15] |=> busy ##1 !busy)
    else $error("window access missing extra cycle");
  AST_POINTER_ADD: assert property (
    startReq && opKind == OPK_POINTER_ADD_CONST && !pwdata[6]
      |=> q.pointerPair0 == $past(q.pointerPair0) + sext6($past(pwdata[5:0])))
    else $error("pointer add result wrong");
  AST_CONST_AND: assert property (
    startReq && opKind == OPK_CONST_AND
      |=> q.acc == ($past(q.acc) & $past(pwdata[7:0])) && q.z == (q.acc == 8'h00))
    else $error("constant AND wrong");
endmodule : cid_core

// ### rtl/cid_decode.sv
module cid_decode
  import cid_pkg::*;
(
  // Instruction word
  input wire logic [13:0] opcode,
  // Pointer pair top bits
  input wire logic ptr0Msb,
  input wire logic ptr1Msb,
  // Classification
  output cid_op_t opKind,
  output logic [1:0] cycles,
  output logic ptrSel,
  output logic windowHit
);
  logic pcChange;

  // Exact codes first, so the pin direction group cannot swallow them
  always_comb begin
    opKind = OPK_ILLEGAL;
    if (opcode == OP_NOP) opKind = OPK_NOP;
    else if (opcode == OP_SWRESET) opKind = OPK_SOFT_RESET;
    else if (opcode == OP_RETURN) opKind = OPK_SUB_RETURN;
    else if (opcode == OP_INT_EXIT) opKind = OPK_INTERRUPT_EXIT;
    else if (opcode == OP_CALL_ACC) opKind = OPK_SUBROUTINE_JUMP_BY_ACC;
    else if (opcode == OP_JUMP_ACC) opKind = OPK_JUMP_BY_ACCUMULATOR;
    else if (opcode == OP_OPTION) opKind = OPK_OPTION_LOAD;
    else if (opcode == OP_STANDBY) opKind = OPK_STANDBY;
    else if (opcode == OP_WD_KICK) opKind = OPK_WATCHDOG_KICK;
    else if (opMatch(opcode, MK_LOW3, MT_PINDIR)) opKind = OPK_PIN_DIRECTION_LOAD;
    else if (opMatch(opcode, MK_LOW3, MT_LDMOD)) opKind = OPK_POINTER_LOAD_ACC;
    else if (opMatch(opcode, MK_LOW3, MT_STMOD)) opKind = OPK_POINTER_STORE_ACC;
    else if (opMatch(opcode, MK_REL, MT_REL)) opKind = OPK_RELATIVE_JUMP;
    else if (opMatch(opcode, MK_CALLJ, MT_CALL)) opKind = OPK_CALL_SUB;
    else if (opMatch(opcode, MK_CALLJ, MT_ABS)) opKind = OPK_ABSOLUTE_JUMP;
    else if (opMatch(opcode, MK_BYTE, MT_RETK)) opKind = OPK_RETURN_WITH_CONSTANT;
    else if (opMatch(opcode, MK_PTRK, MT_PADD)) opKind = OPK_POINTER_ADD_CONST;
    else if (opMatch(opcode, MK_PTRK, MT_LDIX)) opKind = OPK_POINTER_LOAD_IDX;
    else if (opMatch(opcode, MK_PTRK, MT_STIX)) opKind = OPK_POINTER_STORE_IDX;
    else if (opMatch(opcode, MK_BYTE, MT_ANDK)) opKind = OPK_CONST_AND;
    else if (opMatch(opcode, MK_BYTE, MT_ADDK)) opKind = OPK_CONST_ADD;
    else if (opMatch(opcode, MK_BYTE, MT_ANDF)) opKind = OPK_FILE_AND;
  end

  // Pointer select and window detection per operand form
  always_comb begin
    ptrSel = 1'b0;
    windowHit = 1'b0;
    case (opKind)
      OPK_POINTER_LOAD_ACC, OPK_POINTER_STORE_ACC: begin
        ptrSel = opcode[2];
        windowHit = 1'b1;
      end
      OPK_POINTER_LOAD_IDX, OPK_POINTER_STORE_IDX, OPK_POINTER_ADD_CONST: begin
        ptrSel = opcode[6];
        windowHit = (opKind != OPK_POINTER_ADD_CONST);
      end
      OPK_FILE_AND: begin
        ptrSel = opcode[0];
        windowHit = (opcode[6:0] == WINDOW0) || (opcode[6:0] == WINDOW1);
      end
      default: begin
        ptrSel = 1'b0;
      end
    endcase
  end

  // Program counter changers carry a no-op slot
  assign pcChange = opKind inside {OPK_RELATIVE_JUMP, OPK_JUMP_BY_ACCUMULATOR, OPK_CALL_SUB,
    OPK_SUBROUTINE_JUMP_BY_ACC, OPK_ABSOLUTE_JUMP, OPK_INTERRUPT_EXIT,
    OPK_RETURN_WITH_CONSTANT, OPK_SUB_RETURN};
  assign cycles = (pcChange ? CYC_PC_CHANGE : CYC_SINGLE)
    + {1'b0, windowHit & (ptrSel ? ptr1Msb : ptr0Msb)};
endmodule : cid_decode

// ### rtl/cid_pkg.sv
package cid_pkg;
  localparam int PC_W = 15;
  localparam int STACK_DEPTH = 16;
  localparam int MEM_BYTES = 128;
  localparam int PIN_PORTS = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0c;
  localparam logic [7:0] OFS_PTR0 = 8'h10;
  localparam logic [7:0] OFS_PTR1 = 8'h14;
  localparam logic [7:0] OFS_OPTION = 8'h18;
  localparam logic [7:0] OFS_PINDIR_LO = 8'h1c;
  localparam logic [7:0] OFS_PINDIR_HI = 8'h20;
  localparam logic [7:0] OFS_MEMIDX = 8'h24;
  localparam logic [7:0] OFS_MEMDATA = 8'h28;
  // Status register bit positions
  localparam int SB_C = 0;
  localparam int SB_DC = 1;
  localparam int SB_Z = 2;
  localparam int SB_SLEEP_ENTERED = 3;
  localparam int SB_WATCHDOG_EXPIRY = 4;
  localparam int SB_BUSY = 5;
  localparam int SB_STANDBY = 6;
  localparam int SB_GIE = 7;
  localparam int SB_ILLEGAL = 8;
  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [63:0] PINDIR_RESET = 64'hffff_ffff_ffff_ffff;
  localparam logic FLAG_SET_RESET = 1'b1;
  // Cycle counts
  localparam logic [1:0] CYC_SINGLE = 2'h1;
  localparam logic [1:0] CYC_PC_CHANGE = 2'h2;
  // Exact opcodes
  localparam logic [13:0] OP_NOP = 14'h0000;
  localparam logic [13:0] OP_SWRESET = 14'h0001;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_INT_EXIT = 14'h0009;
  localparam logic [13:0] OP_CALL_ACC = 14'h000a;
  localparam logic [13:0] OP_JUMP_ACC = 14'h000b;
  localparam logic [13:0] OP_OPTION = 14'h0062;
  localparam logic [13:0] OP_STANDBY = 14'h0063;
  localparam logic [13:0] OP_WD_KICK = 14'h0064;
  // Masked opcode groups
  localparam logic [13:0] MK_REL = 14'h3e00;
  localparam logic [13:0] MT_REL = 14'h3200;
  localparam logic [13:0] MK_CALLJ = 14'h3800;
  localparam logic [13:0] MT_CALL = 14'h2000;
  localparam logic [13:0] MT_ABS = 14'h2800;
  localparam logic [13:0] MK_BYTE = 14'h3f00;
  localparam logic [13:0] MT_RETK = 14'h3400;
  localparam logic [13:0] MT_ANDK = 14'h3900;
  localparam logic [13:0] MT_ADDK = 14'h3e00;
  localparam logic [13:0] MT_ANDF = 14'h0500;
  localparam logic [13:0] MK_PTRK = 14'h3f80;
  localparam logic [13:0] MT_PADD = 14'h3100;
  localparam logic [13:0] MT_LDIX = 14'h3f00;
  localparam logic [13:0] MT_STIX = 14'h3f80;
  localparam logic [13:0] MK_LOW3 = 14'h3ff8;
  localparam logic [13:0] MT_LDMOD = 14'h0010;
  localparam logic [13:0] MT_STMOD = 14'h0018;
  localparam logic [13:0] MT_PINDIR = 14'h0060;
  // Pointer window file addresses
  localparam logic [6:0] WINDOW0 = 7'h00;
  localparam logic [6:0] WINDOW1 = 7'h01;

  typedef enum logic [4:0] {
    OPK_NOP = 5'h00, OPK_RELATIVE_JUMP = 5'h01, OPK_JUMP_BY_ACCUMULATOR = 5'h02,
    OPK_CALL_SUB = 5'h03, OPK_SUBROUTINE_JUMP_BY_ACC = 5'h04, OPK_ABSOLUTE_JUMP = 5'h05,
    OPK_INTERRUPT_EXIT = 5'h06, OPK_RETURN_WITH_CONSTANT = 5'h07, OPK_SUB_RETURN = 5'h08,
    OPK_WATCHDOG_KICK = 5'h09, OPK_OPTION_LOAD = 5'h0a, OPK_SOFT_RESET = 5'h0b,
    OPK_STANDBY = 5'h0c, OPK_PIN_DIRECTION_LOAD = 5'h0d, OPK_POINTER_ADD_CONST = 5'h0e,
    OPK_POINTER_LOAD_ACC = 5'h0f, OPK_POINTER_LOAD_IDX = 5'h10,
    OPK_POINTER_STORE_ACC = 5'h11, OPK_POINTER_STORE_IDX = 5'h12,
    OPK_CONST_AND = 5'h13, OPK_CONST_ADD = 5'h14, OPK_FILE_AND = 5'h15,
    OPK_ILLEGAL = 5'h1f
  } cid_op_t;

  // Pattern compare shared by every masked group
  function automatic logic opMatch(logic [13:0] op, logic [13:0] mk, logic [13:0] mt);
    return (op & mk) == mt;
  endfunction : opMatch

  // Six-bit signed constant widened to pointer width
  function automatic logic [15:0] sext6(logic [5:0] k);
    return {{10{k[5]}}, k};
  endfunction : sext6
endpackage : cid_pkg

// ### testbench/test_control_and_indirect_op_decode.sv
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module test_control_and_indirect_op_decode
  import cid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, busy;
  logic nopSlot, instrDone, standby, swResetPulse, watchdogKickPulse;
  logic [63:0] pinDirection;
  logic [7:0] paddr, optionValue;
  logic [31:0] pwdata, prdata, seed, a, k, s, ev;
  logic [2:0] fl;
  logic [31:0] expQ[$];
  int mismatches = 0, cmp_count = 0, busyTotal = 0, doneTotal = 0, pulses = 0;

  cid_core uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .nopSlot(nopSlot), .instrDone(instrDone), .standby(standby),
    .swResetPulse(swResetPulse), .watchdogKickPulse(watchdogKickPulse),
    .optionValue(optionValue), .pinDirection(pinDirection));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Xorshift operand source, fixed seed keeps runs repeatable
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin mismatches++; conclude(); end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Read notes its expectation; the watcher compares
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask : rd

  // Issue one opcode and check how many extra cycles it kept busy
  task automatic exec(input logic [13:0] op, input int cyc);
    int n, b0, d0;
    b0 = busyTotal;
    d0 = doneTotal;
    apb(1'b1, OFS_INSTR, {18'h0, op});
    n = 0;
    do begin @(negedge clk); n++; end while (busy !== 1'b0 && n < 20);
    if (n >= 20) begin mismatches++; conclude(); end
    // Second edge lets the completion pulse be counted before we look
    repeat (2) @(posedge clk);
    `CHK("busy cycles", cyc - 1, busyTotal - b0)
    `CHK("instrDone", 1, doneTotal - d0)
  endtask : exec

  // Watcher: oldest note against read data in the access cycle
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
      ev = expQ.pop_front();
      `CHK("prdata", ev, prdata)
      `CHK("pslverr", paddr > OFS_MEMDATA || paddr[1:0] != 2'b00, pslverr)
    end
    if (nopSlot === 1'b1) busyTotal++;
    if (instrDone === 1'b1) doneTotal++;
    if (swResetPulse === 1'b1 || watchdogKickPulse === 1'b1) pulses++;
  end

  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; seed = 32'h04ca;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFS_STATUS, 32'h18);
    rd(OFS_OPTION, 32'hff);
    rd(8'h40, 32'h0);
    $display("reset test done");
    // Random add then AND; AND must leave carry bits alone
    repeat (4) begin
      seed = xs(seed); a = seed & 32'hff; seed = xs(seed); k = seed & 32'hff;
      apb(1'b1, OFS_ACC, a);
      exec(MT_ADDK | k[13:0], 1);
      s = a + k;
      fl = {s[7:0] == 8'h0, a[3:0] + k[3:0] > 32'd15, s[8]};
      rd(OFS_ACC, s & 32'hff);
      rd(OFS_STATUS, {27'h0, 2'b11, fl});
      seed = xs(seed); k = seed & 32'hff;
      exec(MT_ANDK | k[13:0], 1);
      fl[2] = (s[7:0] & k[7:0]) == 8'h0;
      rd(OFS_ACC, {24'h0, s[7:0] & k[7:0]});
      rd(OFS_STATUS, {27'h0, 2'b11, fl});
    end
    $display("alu test done");
    apb(1'b1, OFS_PTR1, 32'hfffe);
    exec(14'h3145, 1);
    rd(OFS_PTR1, 32'h3);
    apb(1'b1, OFS_PTR0, 32'h1);
    exec(14'h313e, 1);
    rd(OFS_PTR0, 32'hffff);
    $display("pointer add test done");
    // Store post-increment, reload pre-decrement
    apb(1'b1, OFS_PTR0, 32'h10);
    apb(1'b1, OFS_ACC, 32'h5a);
    exec(14'h001a, 1);
    rd(OFS_PTR0, 32'h11);
    apb(1'b1, OFS_ACC, 32'h0);
    exec(14'h0011, 1);
    rd(OFS_ACC, 32'h5a);
    rd(OFS_PTR0, 32'h10);
    // Window access with pointer top bit set costs a cycle
    apb(1'b1, OFS_PTR0, 32'h8010);
    apb(1'b1, OFS_ACC, 32'h0f);
    exec(14'h0500, 2);
    rd(OFS_ACC, 32'h0a);
    $display("indirect test done");
    apb(1'b1, OFS_PC, 32'h123);
    exec(14'h2456, 2);
    rd(OFS_PC, 32'h456);
    exec(OP_RETURN, 2);
    rd(OFS_PC, 32'h124);
    apb(1'b1, OFS_ACC, 32'h3c);
    exec(OP_OPTION, 1);
    `CHK("optionValue", 8'h3c, optionValue)
    // Branches, returns and inherent operations
    apb(1'b1, OFS_PC, 32'h100);
    exec(14'h33fe, 2);
    rd(OFS_PC, 32'hff);
    exec(OP_JUMP_ACC, 2);
    rd(OFS_PC, 32'h13c);
    exec(OP_CALL_ACC, 2);
    rd(OFS_PC, 32'h13c);
    exec(14'h34a5, 2);
    rd(OFS_PC, 32'h13d);
    rd(OFS_ACC, 32'ha5);
    apb(1'b1, OFS_STATUS, 32'h18);
    exec(14'h2010, 2);
    exec(OP_INT_EXIT, 2);
    rd(OFS_PC, 32'h13e);
    rd(OFS_STATUS, 32'h98);
    apb(1'b1, OFS_STATUS, 32'h0);
    exec(OP_WD_KICK, 1);
    rd(OFS_STATUS, 32'h18);
    exec(OP_STANDBY, 1);
    rd(OFS_STATUS, 32'h50);
    `CHK("standby", 1'b1, standby)
    exec(14'h0061, 1);
    `CHK("pinDirection", 64'hffff_ffff_ffff_a5ff, pinDirection)
    `CHK("standby", 1'b0, standby)
    // Indexed forms through a pointer with its top bit set
    apb(1'b1, OFS_PTR1, 32'h8020);
    exec(14'h3fc2, 2);
    apb(1'b1, OFS_ACC, 32'h0);
    exec(14'h3f42, 2);
    rd(OFS_ACC, 32'ha5);
    exec(OP_SWRESET, 1);
    rd(OFS_PC, 32'h0);
    `CHK("pinDirection", PINDIR_RESET, pinDirection)
    `CHK("pulses", 2, pulses)
    $display("control test done");
    conclude();
  end
endmodule : test_control_and_indirect_op_decode
